// file: rtl/modbus_fn_pkg.sv
package modbus_fn_pkg;

    localparam logic [7:0] FN_RD_COILS  = 8'h01;
    localparam logic [7:0] FN_RD_DISC   = 8'h02;
    localparam logic [7:0] FN_RD_HOLD   = 8'h03;
    localparam logic [7:0] FN_RD_INPUT  = 8'h04;
    localparam logic [7:0] FN_WR_COIL   = 8'h05;
    localparam logic [7:0] FN_WR_REG    = 8'h06;
    localparam logic [7:0] FN_EXC_STAT  = 8'h07;
    localparam logic [7:0] FN_DIAG      = 8'h08;
    localparam logic [7:0] FN_WR_COILS  = 8'h0F;
    localparam logic [7:0] FN_WR_REGS   = 8'h10;
    localparam logic [7:0] FN_DEV_ID    = 8'h2B;

    localparam logic [7:0] EXC_FLAG     = 8'h80;
    localparam logic [7:0] EXC_NONE     = 8'h00;
    localparam logic [7:0] EXC_ILL_FUNC = 8'h01;
    localparam logic [7:0] EXC_ILL_ADDR = 8'h02;
    localparam logic [7:0] EXC_ILL_VAL  = 8'h03;

    localparam int NUM_COILS = 10;
    localparam int NUM_DISC  = 70;
    localparam int NUM_HOLD  = 12;
    localparam int NUM_INPUT = 45;

    localparam logic [15:0] MAX_COILS = 16'h000A;
    localparam logic [15:0] MAX_DISC  = 16'h0046;
    localparam logic [15:0] MAX_HOLD  = 16'h000C;
    localparam logic [15:0] MAX_INPUT = 16'h002D;

    localparam logic [15:0] COIL_OFF = 16'h0000;
    localparam logic [15:0] COIL_ON  = 16'hFF00;

    localparam logic [7:0] COIL_BYTES_MAX = 8'h01;
    localparam logic [7:0] DISC_BYTES_MAX = 8'h07;

    localparam logic [2:0] REQ_LEN  = 3'h6;
    localparam logic [2:0] MIN_LEN  = 3'h2;
    localparam logic [7:0] EXC_LEN  = 8'h03;
    localparam logic [7:0] ECHO_LEN = 8'h06;
    localparam logic [7:0] HDR_LEN  = 8'h03;

    typedef struct packed {
        logic [7:0] data;
        logic       last;
    } byte_beat_type;

    typedef struct packed {
        logic [7:0]  addr;
        logic [7:0]  func;
        logic [15:0] field_a;
        logic [15:0] field_b;
    } request_type;

    typedef enum logic [1:0] {ST_RECV, ST_EVAL, ST_SEND} state_type;

endpackage

// file: rtl/modbus_slave_function_handler.sv
// Overview of operation
// - codes 1-8, 15, 16 and 43 are known and any other is unsupported.
// - codes follow the public protocol plus local ranges and layouts.
// - read coils takes start 0 to 9 and quantity 1 to 10.
// - a good read-coils answer has byte count 1 and one coil byte.
// - read discrete inputs takes start 0 to 69 and quantity 1 to 70.
// - a good discrete-input answer has byte count 1 to 7 and packed bits.
// - read holding registers takes start 0 to 11 and quantity 1 to 12.
// - a good holding-register answer has count 2q then two bytes each.
// - read input registers takes start 0 to 44 and quantity 1 to 45.
// - a good input-register answer has code 4, count 2q and the words.
// - single coil write: address 0 to 9, 0x0000 or 0xFF00, echoed.
// - single register write: address 0 to 11, address and value echoed.
// - the written value is stored raw in the addressed holding register.
// - an error answer is address, code plus 128 and exception 1 to 3.
module modbus_slave_function_handler
    import modbus_fn_pkg::*;
(
    input  wire logic                      clk_i,
    input  wire logic                      srst_i,
    input  wire logic [7:0]                station_addr_i,
    input  wire byte_beat_type             rx_beat_i,
    input  wire logic                      rx_valid_i,
    input  wire logic                      rx_crc_ok_i,
    output logic                           rx_ready_o,
    output byte_beat_type                  tx_beat_o,
    output logic                           tx_valid_o,
    input  wire logic                      tx_ready_i,
    input  wire logic [NUM_DISC-1:0]       disc_i,
    input  wire logic [NUM_INPUT-1:0][15:0] input_regs_i,
    output logic [NUM_COILS-1:0]           coils_o,
    output logic [NUM_HOLD-1:0][15:0]      hold_regs_o,
    output logic                           hold_wr_o,
    output logic [3:0]                     hold_wr_addr_o,
    output logic [15:0]                    hold_wr_data_o,
    output logic                           ext_req_o,
    output logic [7:0]                     ext_func_o
);

    state_type               state_reg;
    logic [5:0][7:0]         req_bytes_reg;
    logic [2:0]              rx_cnt_reg;
    logic [2:0]              frame_len_reg;
    logic                    crc_ok_reg;
    logic [7:0]              exc_reg;
    logic [7:0]              len_reg;
    logic [7:0]              bc_reg;
    logic [7:0]              idx_reg;
    logic                    tx_valid_reg;
    byte_beat_type           tx_beat_reg;
    logic [NUM_COILS-1:0]    coils_reg;
    logic [NUM_HOLD-1:0][15:0] hold_reg;
    logic                    hold_wr_reg;
    logic [3:0]              hold_wr_addr_reg;
    logic [15:0]             hold_wr_data_reg;
    logic                    ext_req_reg;
    logic [7:0]              ext_func_reg;

    request_type             req;
    logic [15:0]             fa;
    logic [15:0]             fb;
    logic [16:0]             span;
    logic                    rx_take;
    logic                    known;
    logic                    handled;
    logic                    frame_match;
    logic                    respond;
    logic                    wr_ok;
    logic [7:0]              chk_exc;
    logic [7:0]              eval_exc;
    logic [7:0]              bit_bytes;
    logic [7:0]              eval_bc;
    logic [7:0]              eval_len;
    logic                    tx_load;
    logic                    tx_done;
    logic [7:0]              k;
    logic [5:0]              ri;
    logic [71:0]             bit_src;
    logic [71:0]             bit_packed;
    logic [15:0]             word;
    logic [7:0]              out_byte;

    assign req     = req_bytes_reg;
    assign fa      = req.field_a;
    assign fb      = req.field_b;
    assign span    = {1'b0, fa} + {1'b0, fb};
    assign rx_ready_o = (state_reg == ST_RECV);
    assign rx_take = rx_valid_i && rx_ready_o;

    // quantity is judged before the address span
    function automatic logic [7:0] range_exc(input logic [15:0] q,
                                             input logic [16:0] s,
                                             input logic [15:0] mx);
        if (q == 16'h0000 || q > mx) begin
            return EXC_ILL_VAL;
        end else if (s > {1'b0, mx}) begin
            return EXC_ILL_ADDR;
        end
        return EXC_NONE;
    endfunction

    always_comb begin
        chk_exc = EXC_NONE;
        known   = 1'b1;
        handled = 1'b1;
        case (req.func)
            FN_RD_COILS: chk_exc = range_exc(fb, span, MAX_COILS);
            FN_RD_DISC:  chk_exc = range_exc(fb, span, MAX_DISC);
            FN_RD_HOLD:  chk_exc = range_exc(fb, span, MAX_HOLD);
            FN_RD_INPUT: chk_exc = range_exc(fb, span, MAX_INPUT);
            FN_WR_COIL: begin
                if (fb != COIL_OFF && fb != COIL_ON) begin
                    chk_exc = EXC_ILL_VAL;
                end else if (fa >= MAX_COILS) begin
                    chk_exc = EXC_ILL_ADDR;
                end
            end
            FN_WR_REG: begin
                if (fa >= MAX_HOLD) begin
                    chk_exc = EXC_ILL_ADDR;
                end
            end
            FN_EXC_STAT, FN_DIAG, FN_WR_COILS, FN_WR_REGS, FN_DEV_ID: begin
                handled = 1'b0;
            end
            default: begin
                known   = 1'b0;
                handled = 1'b0;
            end
        endcase
    end

    assign eval_exc    = known ? chk_exc : EXC_ILL_FUNC;
    assign frame_match = crc_ok_reg && (req.addr == station_addr_i)
                         && (frame_len_reg >= MIN_LEN);
    assign respond     = frame_match
                         && (!known || (handled && frame_len_reg == REQ_LEN));
    assign wr_ok       = respond && known && handled && eval_exc == EXC_NONE;
    assign bit_bytes   = 8'((fb[7:0] + 8'h07) >> 3);

    always_comb begin
        eval_bc  = 8'h00;
        eval_len = ECHO_LEN;
        if (eval_exc != EXC_NONE) begin
            eval_len = EXC_LEN;
        end else if (req.func == FN_RD_COILS) begin
            eval_bc = COIL_BYTES_MAX;
        end else if (req.func == FN_RD_DISC) begin
            eval_bc = (bit_bytes > DISC_BYTES_MAX) ? DISC_BYTES_MAX
                                                   : bit_bytes;
        end else if (req.func == FN_RD_HOLD || req.func == FN_RD_INPUT) begin
            eval_bc = {fb[6:0], 1'b0};
        end
        if (eval_exc == EXC_NONE && req.func <= FN_RD_INPUT) begin
            eval_len = HDR_LEN + eval_bc;
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            state_reg <= ST_RECV;
        end else begin
            case (state_reg)
                ST_RECV: begin
                    if (rx_take && rx_beat_i.last) begin
                        state_reg <= ST_EVAL;
                    end
                end
                ST_EVAL: state_reg <= respond ? ST_SEND : ST_RECV;
                ST_SEND: begin
                    if (tx_done) begin
                        state_reg <= ST_RECV;
                    end
                end
                default: state_reg <= ST_RECV;
            endcase
        end
    end

    // bytes past the sixth are not kept; the count stops at six and a longer frame gets length 7
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            req_bytes_reg <= '0;
            rx_cnt_reg    <= 3'h0;
            frame_len_reg <= 3'h0;
            crc_ok_reg    <= 1'b0;
        end else if (rx_take) begin
            if (rx_cnt_reg < REQ_LEN) begin
                req_bytes_reg[3'h5 - rx_cnt_reg] <= rx_beat_i.data;
            end
            if (rx_beat_i.last) begin
                rx_cnt_reg    <= 3'h0;
                frame_len_reg <= (rx_cnt_reg < REQ_LEN) ? rx_cnt_reg + 3'h1
                                                        : 3'h7;
                crc_ok_reg    <= rx_crc_ok_i;
            end else if (rx_cnt_reg < REQ_LEN) begin
                rx_cnt_reg <= rx_cnt_reg + 3'h1;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            exc_reg <= EXC_NONE;
            len_reg <= 8'h00;
            bc_reg  <= 8'h00;
        end else if (state_reg == ST_EVAL) begin
            exc_reg <= eval_exc;
            len_reg <= eval_len;
            bc_reg  <= eval_bc;
        end
    end

    assign k   = idx_reg - HDR_LEN;
    assign ri  = fa[5:0] + k[6:1];
    assign bit_src = (req.func == FN_RD_COILS) ? 72'(coils_reg)
                                               : 72'(disc_i);
    assign bit_packed = (bit_src >> fa[6:0])
                        & ~({72{1'b1}} << fb[6:0]);

    always_comb begin
        word = 16'h0000;
        if (req.func == FN_RD_HOLD && ri < 6'(NUM_HOLD)) begin
            word = hold_reg[ri[3:0]];
        end else if (req.func == FN_RD_INPUT && ri < 6'(NUM_INPUT)) begin
            word = input_regs_i[ri];
        end
    end

    always_comb begin
        out_byte = 8'h00;
        if (idx_reg == 8'h00) begin
            out_byte = req.addr;
        end else if (idx_reg == 8'h01) begin
            out_byte = (exc_reg != EXC_NONE) ? (req.func | EXC_FLAG)
                                             : req.func;
        end else if (exc_reg != EXC_NONE) begin
            out_byte = exc_reg;
        end else if (req.func == FN_WR_COIL || req.func == FN_WR_REG) begin
            case (idx_reg)
                8'h02:   out_byte = fa[15:8];
                8'h03:   out_byte = fa[7:0];
                8'h04:   out_byte = fb[15:8];
                default: out_byte = fb[7:0];
            endcase
        end else if (idx_reg == 8'h02) begin
            out_byte = bc_reg;
        end else if (req.func <= FN_RD_DISC) begin
            out_byte = bit_packed[{k[2:0], 3'b000} +: 8];
        end else begin
            out_byte = k[0] ? word[7:0] : word[15:8];
        end
    end

    assign tx_load = (state_reg == ST_SEND) && (!tx_valid_reg || tx_ready_i);
    assign tx_done = tx_load && (idx_reg == len_reg);

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            idx_reg      <= 8'h00;
            tx_valid_reg <= 1'b0;
            tx_beat_reg  <= '0;
        end else if (state_reg == ST_EVAL) begin
            idx_reg <= 8'h00;
        end else if (tx_load) begin
            if (idx_reg < len_reg) begin
                tx_valid_reg     <= 1'b1;
                tx_beat_reg.data <= out_byte;
                tx_beat_reg.last <= (idx_reg == len_reg - 8'h01);
                idx_reg          <= idx_reg + 8'h01;
            end else begin
                tx_valid_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            coils_reg <= '0;
        end else if (state_reg == ST_EVAL && wr_ok
                     && req.func == FN_WR_COIL) begin
            coils_reg[fa[3:0]] <= (fb == COIL_ON);
        end
    end

    for (genvar i = 0; i < NUM_HOLD; i++) begin : g_hold
        always_ff @(posedge clk_i) begin
            if (srst_i) begin
                hold_reg[i] <= 16'h0000;
            end else if (state_reg == ST_EVAL && wr_ok
                         && req.func == FN_WR_REG && fa[3:0] == 4'(i)) begin
                hold_reg[i] <= fb;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            hold_wr_reg      <= 1'b0;
            hold_wr_addr_reg <= 4'h0;
            hold_wr_data_reg <= 16'h0000;
            ext_req_reg      <= 1'b0;
            ext_func_reg     <= 8'h00;
        end else begin
            hold_wr_reg <= (state_reg == ST_EVAL) && wr_ok
                           && req.func == FN_WR_REG;
            ext_req_reg <= (state_reg == ST_EVAL) && frame_match
                           && known && !handled;
            if (state_reg == ST_EVAL) begin
                hold_wr_addr_reg <= fa[3:0];
                hold_wr_data_reg <= fb;
                ext_func_reg     <= req.func;
            end
        end
    end

    assign tx_beat_o      = tx_beat_reg;
    assign tx_valid_o     = tx_valid_reg;
    assign coils_o        = coils_reg;
    assign hold_regs_o    = hold_reg;
    assign hold_wr_o      = hold_wr_reg;
    assign hold_wr_addr_o = hold_wr_addr_reg;
    assign hold_wr_data_o = hold_wr_data_reg;
    assign ext_req_o      = ext_req_reg;
    assign ext_func_o     = ext_func_reg;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (srst_i);

    logic ev;
    assign ev = (state_reg == ST_EVAL) && frame_match;

    // a one-byte frame may follow a drop at once, so only the first cycle
    // must be back in receive
    property p_drop;
        (state_reg == ST_EVAL && !frame_match)
            |=> state_reg == ST_RECV && !tx_valid_reg ##1 !tx_valid_reg;
    endproperty
    a_drop: assert property (p_drop) else $error("frame answered");

    property p_bad_func;
        (ev && !known) |=> (exc_reg == EXC_ILL_FUNC && len_reg == EXC_LEN);
    endproperty
    a_bad_func: assert property (p_bad_func) else $error("bad code");

    property p_coil_ok;
        (ev && req.func == FN_RD_COILS && fb >= 16'h0001 && span <= 17'h0000A)
            |=> (exc_reg == EXC_NONE && len_reg == 8'h04 && bc_reg == 8'h01);
    endproperty
    a_coil_ok: assert property (p_coil_ok) else $error("coil read");

    property p_disc_qty;
        (ev && req.func == FN_RD_DISC && fb > 16'h0046)
            |=> exc_reg == EXC_ILL_VAL;
    endproperty
    a_disc_qty: assert property (p_disc_qty) else $error("disc qty");

    property p_hold_span;
        (ev && req.func == FN_RD_HOLD && fb == 16'h0001 && fa > 16'h000B)
            |=> exc_reg == EXC_ILL_ADDR;
    endproperty
    a_hold_span: assert property (p_hold_span) else $error("hold span");

    property p_hold_len;
        (ev && req.func == FN_RD_HOLD && eval_exc == EXC_NONE)
            |=> len_reg == 8'h03 + {$past(fb[6:0]), 1'b0};
    endproperty
    a_hold_len: assert property (p_hold_len) else $error("hold len");

    property p_input_span;
        (ev && req.func == FN_RD_INPUT && fb == 16'h0002 && fa == 16'h002C)
            |=> exc_reg == EXC_ILL_ADDR;
    endproperty
    a_input_span: assert property (p_input_span) else $error("input span");

    property p_coil_wr;
        (ev && frame_len_reg == REQ_LEN && req.func == FN_WR_COIL
         && fb == COIL_ON && fa < 16'h000A)
            |=> coils_reg[$past(fa[3:0])];
    endproperty
    a_coil_wr: assert property (p_coil_wr) else $error("coil write");

    property p_reg_wr;
        (ev && frame_len_reg == REQ_LEN && req.func == FN_WR_REG
         && fa < 16'h000C) |=> ##1 hold_reg[fa[3:0]] == fb;
    endproperty
    a_reg_wr: assert property (p_reg_wr) else $error("reg write");

    property p_exc_code;
        (tx_valid_reg && idx_reg == 8'h02 && exc_reg != EXC_NONE)
            |-> tx_beat_reg.data == (req.func | 8'h80);
    endproperty
    a_exc_code: assert property (p_exc_code) else $error("exc code");

    property p_hi_first;
        (tx_valid_reg && idx_reg == 8'h04 && exc_reg == EXC_NONE
         && req.func == FN_RD_HOLD)
            |-> tx_beat_reg.data == hold_reg[fa[3:0]][15:8];
    endproperty
    a_hi_first: assert property (p_hi_first) else $error("byte order");

    c_exc: cover property (tx_valid_reg && exc_reg != EXC_NONE
                           && tx_beat_reg.last);
    c_hold: cover property (tx_valid_reg && req.func == FN_RD_HOLD
                            && tx_beat_reg.last && tx_ready_i);
    c_wr: cover property (hold_wr_reg);
    c_drop: cover property (state_reg == ST_EVAL && !frame_match);

endmodule // modbus_slave_function_handler

// file: testbench/modbus_master_sink.sv
module modbus_master_sink
    import modbus_fn_pkg::*;
(
    input  wire logic clk_i,
    input  wire logic srst_i,
    input  wire logic slow_i,
    output logic      tx_ready_o
);
    timeunit 1ns;
    timeprecision 1ps;

    // a slow master takes response bytes on roughly half the cycles
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            tx_ready_o <= 1'b0;
        end else if (slow_i) begin
            tx_ready_o <= 1'($urandom % 2);
        end else begin
            tx_ready_o <= 1'b1;
        end
    end
endmodule // modbus_master_sink

// file: testbench/testbench.sv
`define CHK(n, e, g) check_val(n, 32'(e), 32'(g), (e) === (g))
module testbench
    import modbus_fn_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic                        clk_i = 1'b0;
    logic                        srst_i = 1'b1;
    logic                        rx_valid_i = 1'b0;
    logic                        rx_crc_ok_i = 1'b0;
    logic                        slow = 1'b0;
    logic [7:0]                  station = 8'h2A;
    byte_beat_type               rx_beat_i = '0;
    byte_beat_type               tx_beat_o;
    byte_beat_type               e;
    logic                        rx_ready_o;
    logic                        tx_valid_o;
    logic                        tx_ready;
    logic                        hold_wr_o;
    logic                        ext_req_o;
    logic [7:0]                  ext_func_o;
    logic [NUM_DISC-1:0]         disc_i = '0;
    logic [NUM_INPUT-1:0][15:0]  input_regs_i = '0;
    logic [NUM_COILS-1:0]        coils_o;
    logic [NUM_HOLD-1:0][15:0]   hold_regs_o;
    logic [3:0]                  hold_wr_addr_o;
    logic [15:0]                 hold_wr_data_o;
    logic [19:0]                 w;
    logic [7:0]                  x;
    logic [NUM_COILS-1:0]        coil_m = '0;
    logic [15:0]                 hold_m [NUM_HOLD] = '{default: 16'h0000};
    byte_beat_type               exp_q [$];
    logic [7:0]                  ext_q [$];
    logic [19:0]                 wr_q [$];
    int                          failures = 0;
    int                          checked = 0;
    logic [7:0]                  x_list [11] = '{8'h07, 8'h08, 8'h0F, 8'h10,
        8'h2B, 8'h00, 8'h09, 8'h0A, 8'h11, 8'h2C, 8'h7F};

    always #2 clk_i = ~clk_i;

    modbus_slave_function_handler dut (
        .clk_i(clk_i), .srst_i(srst_i), .station_addr_i(station),
        .rx_beat_i(rx_beat_i), .rx_valid_i(rx_valid_i),
        .rx_crc_ok_i(rx_crc_ok_i), .rx_ready_o(rx_ready_o),
        .tx_beat_o(tx_beat_o), .tx_valid_o(tx_valid_o),
        .tx_ready_i(tx_ready), .disc_i(disc_i),
        .input_regs_i(input_regs_i), .coils_o(coils_o),
        .hold_regs_o(hold_regs_o), .hold_wr_o(hold_wr_o),
        .hold_wr_addr_o(hold_wr_addr_o), .hold_wr_data_o(hold_wr_data_o),
        .ext_req_o(ext_req_o), .ext_func_o(ext_func_o)
    );

    modbus_master_sink master (
        .clk_i(clk_i), .srst_i(srst_i), .slow_i(slow), .tx_ready_o(tx_ready)
    );

    task automatic check_val(string n, logic [31:0] ev, gv, bit ok);
        checked++;
        if (!ok) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", n, ev, gv);
        end
    endtask

    task automatic report_and_stop();
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic fail_stop(string n);
        failures++;
        $display("MISMATCH %s expected done seen timeout", n);
        report_and_stop();
    endtask

    task automatic push(logic [7:0] d, logic l);
        exp_q.push_back('{data: d, last: l});
    endtask

    // reference model of the response for one accepted request
    task automatic expect_rsp(logic [7:0] f, logic [15:0] a, q);
        int mx, ex, bc;
        logic [7:0] b;
        logic [15:0] v;
        mx = f == 1 ? 10 : f == 2 ? 70 : f == 3 ? 12 : f == 4 ? 45 : 0;
        ex = 0;
        if (f >= 1 && f <= 4) begin
            if (q == 0 || q > mx) ex = 3;
            else if (a + q > mx) ex = 2;
        end else if (f == 5) begin
            if (q != COIL_OFF && q != COIL_ON) ex = 3;
            else if (a > 9) ex = 2;
        end else if (f == 6) begin
            if (a > 11) ex = 2;
        end else begin
            ex = 1;
        end
        push(station, 1'b0);
        if (ex != 0) begin
            push(f | EXC_FLAG, 1'b0);
            push(8'(ex), 1'b1);
            return;
        end
        push(f, 1'b0);
        if (f == 1 || f == 2) begin
            bc = f == 1 ? 1 : ((q + 7) / 8 > 7 ? 7 : (q + 7) / 8);
            push(8'(bc), 1'b0);
            for (int k = 0; k < bc; k++) begin
                b = '0;
                for (int i = 0; i < 8; i++)
                    if (8 * k + i < q)
                        b[i] = f == 1 ? coil_m[a + i] : disc_i[a + 8 * k + i];
                push(b, k == bc - 1);
            end
        end else if (f == 3 || f == 4) begin
            push(8'(2 * q), 1'b0);
            for (int i = 0; i < q; i++) begin
                v = f == 3 ? hold_m[a + i] : input_regs_i[a + i];
                push(v[15:8], 1'b0);
                push(v[7:0], i == q - 1);
            end
        end else begin
            push(a[15:8], 1'b0);
            push(a[7:0], 1'b0);
            push(q[15:8], 1'b0);
            push(q[7:0], 1'b1);
            if (f == 5) coil_m[a] = q == COIL_ON;
            if (f == 6) hold_m[a] = q;
            if (f == 6) wr_q.push_back({a[3:0], q});
        end
    endtask

    task automatic send(logic [7:0] st, f, logic [15:0] a, q, int n, bit crc);
        logic [7:0] by [7];
        int t;
        by = '{st, f, a[15:8], a[7:0], q[15:8], q[7:0], 8'h5A};
        for (int i = 0; i < n; i++) begin
            t = 0;
            while (!rx_ready_o) begin
                @(negedge clk_i);
                if (++t > 200) fail_stop("rx_ready");
            end
            rx_valid_i = 1'b1;
            rx_beat_i = '{data: by[i], last: i == n - 1};
            rx_crc_ok_i = crc;
            @(negedge clk_i);
        end
        rx_valid_i = 1'b0;
        `CHK("rx_ready_eval", 1'b0, rx_ready_o);
    endtask

    task automatic settle();
        int t;
        t = 0;
        while (exp_q.size() != 0 || !rx_ready_o) begin
            @(negedge clk_i);
            if (++t > 2000) fail_stop("idle");
        end
        repeat (4) @(negedge clk_i);
        `CHK("side_pulses", 0, wr_q.size() + ext_q.size());
        `CHK("coils", coil_m, coils_o);
        for (int i = 0; i < NUM_HOLD; i++)
            `CHK("hold_reg", hold_m[i], hold_regs_o[i]);
    endtask

    task automatic txn(logic [7:0] f, logic [15:0] a, q);
        if (f inside {7, 8, 15, 16, 43}) ext_q.push_back(f);
        else expect_rsp(f, a, q);
        send(station, f, a, q, 6, 1'b1);
        settle();
    endtask

    // response, write and hand-off monitor
    always @(posedge clk_i) begin
        if (!srst_i && tx_valid_o && tx_ready) begin
            if (exp_q.size() == 0) `CHK("tx_extra", 1'b0, 1'b1);
            else begin
                e = exp_q.pop_front();
                `CHK("tx_beat", e, tx_beat_o);
            end
        end
        if (!srst_i && hold_wr_o) begin
            w = wr_q.size() != 0 ? wr_q.pop_front() : 20'hXXXXX;
            `CHK("hold_wr", w, {hold_wr_addr_o, hold_wr_data_o});
        end
        if (!srst_i && ext_req_o) begin
            x = ext_q.size() != 0 ? ext_q.pop_front() : 8'hXX;
            `CHK("ext_func", x, ext_func_o);
        end
    end

    initial begin
        void'($urandom(16290));
        repeat (20) @(negedge clk_i);
        srst_i = 1'b0;
        disc_i = NUM_DISC'({$urandom(), $urandom(), $urandom()});
        for (int i = 0; i < NUM_INPUT; i++) input_regs_i[i] = 16'($urandom());
        txn(5, 9, COIL_ON);
        txn(5, 0, COIL_ON);
        txn(5, 3, COIL_ON);
        txn(5, 3, COIL_OFF);
        txn(5, 2, 16'h1234);
        txn(5, 10, COIL_ON);
        txn(1, 0, 10);
        txn(1, 9, 1);
        txn(1, 9, 2);
        txn(1, 0, 0);
        txn(1, 0, 11);
        for (int i = 0; i < 12; i++) txn(6, 16'(i), 16'($urandom()));
        txn(6, 12, 16'h0001);
        txn(3, 0, 12);
        txn(3, 11, 2);
        txn(3, 0, 13);
        txn(3, 12, 1);
        slow = 1'b1;
        txn(2, 0, 70);
        txn(2, 69, 1);
        txn(2, 5, 9);
        txn(2, 60, 11);
        txn(2, 0, 71);
        txn(4, 0, 45);
        txn(4, 44, 1);
        txn(4, 44, 2);
        txn(4, 0, 0);
        foreach (x_list[i]) txn(x_list[i], 0, 1);
        repeat (20) txn(8'(1 + $urandom % 6), 16'($urandom % 16),
                        16'($urandom % 16));
        send(station + 8'h01, 3, 0, 1, 6, 1'b1);
        settle();
        send(station, 3, 0, 1, 6, 1'b0);
        settle();
        send(station, 3, 0, 1, 7, 1'b1);
        settle();
        send(station, 3, 0, 1, 1, 1'b1);
        settle();
        txn(3, 0, 1);
        report_and_stop();
    end

endmodule // testbench
